// File: hdl/tdm_pkg.sv
// Constants for the table read and data memory map block
// Notes on behaviour
// - Table read low byte goes to operand register at 80H-FFH, dropped below 80H
// - High byte into table high latch, all 8 bits from the word
// - Full read addresses from both pointer registers
// - Last-page read uses page 700H, ignores high pointer
// - Table high latch is read-only to software
// - Table instructions take two instruction cycles
// - Data memory is two byte-wide banks
// - 00H-7FH special registers, bank 0 upper general storage
// - Bank 1 upper half is LED PWM buffer A/B
// - Unused special addresses read 00H, no side effect
// - Some special registers are read-only
// - General storage supports single-bit set and clear
// - Direct addressing always reaches bank 0
// - Bank pointer bit 0 selects bank, upper bits zero
package tdm_pkg;
  localparam int unsigned PADDR_W = 11;
  localparam logic [7:0] ADDR_MP1 = 8'h03;
  localparam logic [7:0] ADDR_BANK_PTR = 8'h04;
  localparam logic [7:0] ADDR_TBL_LOW = 8'h07;
  localparam logic [7:0] ADDR_TBL_HIGH_LATCH = 8'h08;
  localparam logic [7:0] ADDR_TBL_HI_PTR = 8'h09;
  localparam logic [7:0] ADDR_IND1 = 8'h02;
  localparam logic [7:0] ADDR_IND0 = 8'h00;
  localparam logic [7:0] ADDR_MP0 = 8'h01;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BUF_B_START = 8'hC0;
  localparam int unsigned TBL_CYCLES = 2;
  typedef enum logic [1:0] {
    TDM_OP_READ, TDM_OP_WRITE, TDM_OP_BSET, TDM_OP_BCLR
  } tdm_op_t;
endpackage

// File: hdl/tdm_core.sv
// Table read path and two-bank data memory decode
`timescale 1ns/100ps
`default_nettype none
module tdm_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Data memory access from the core
  input wire logic acc_valid,
  input wire tdm_pkg::tdm_op_t acc_op,
  input wire logic [7:0] acc_addr,
  input wire logic acc_indirect,
  input wire logic [2:0] acc_bit,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata,
  // Table read command
  input wire logic tbl_start,
  input wire logic tbl_last_page,
  input wire logic [7:0] tbl_dest,
  output logic tbl_busy,
  output logic tbl_done,
  // Program memory read port
  output logic [10:0] prog_addr,
  input wire logic [15:0] prog_data,
  // State shown outward
  output logic [7:0] table_high_latch,
  output logic bank_select_bit
);
  logic [7:0] gp_mem [128];
  logic [7:0] pwm_mem [128];
  logic [7:0] tbl_low, tbl_hi_ptr, mp0, mp1;
  logic [1:0] tbl_cnt;
  logic [7:0] tbl_dest_q;
  logic [7:0] eff_addr;
  logic eff_bank1;
  logic [7:0] cur;
  logic [7:0] next_byte;
  logic wr_en;
  logic tbl_last_page_q;
  // Sampling helpers, so that $past only ever looks back on a plain signal
  logic [7:0] prog_hi;
  logic [7:0] prog_lo;
  logic [6:0] dest_idx;
  logic [6:0] eff_idx;
  logic next_bit0;

  // Resolve indirect addresses; direct access always hits bank 0
  always_comb begin
    eff_addr = acc_addr;
    eff_bank1 = 1'b0;
    if (acc_addr == tdm_pkg::ADDR_IND0) begin
      eff_addr = mp0;
    end else if (acc_addr == tdm_pkg::ADDR_IND1) begin
      eff_addr = mp1;
      eff_bank1 = bank_select_bit;
    end
  end

  // Read decode; unused special addresses give 00H
  always_comb begin
    cur = tdm_pkg::RESET_BYTE;
    if (eff_addr[7]) begin
      cur = eff_bank1 ? pwm_mem[eff_addr[6:0]] : gp_mem[eff_addr[6:0]];
    end else begin
      case (eff_addr)
        tdm_pkg::ADDR_MP0: cur = mp0;
        tdm_pkg::ADDR_MP1: cur = mp1;
        tdm_pkg::ADDR_BANK_PTR: cur = {7'h00, bank_select_bit};
        tdm_pkg::ADDR_TBL_LOW: cur = tbl_low;
        tdm_pkg::ADDR_TBL_HIGH_LATCH: cur = table_high_latch;
        tdm_pkg::ADDR_TBL_HI_PTR: cur = tbl_hi_ptr;
        default: cur = tdm_pkg::RESET_BYTE;
      endcase
    end
  end

  // Read data registered at the access edge; the core takes it in the next cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_rdata <= tdm_pkg::RESET_BYTE;
    end else if (acc_valid) begin
      acc_rdata <= cur;
    end
  end

  // Bit set/clear is a read-modify-write of one byte
  always_comb begin
    case (acc_op)
      tdm_pkg::TDM_OP_BSET: next_byte = cur | (8'h01 << acc_bit);
      tdm_pkg::TDM_OP_BCLR: next_byte = cur & ~(8'h01 << acc_bit);
      default: next_byte = acc_wdata;
    endcase
  end
  assign wr_en = acc_valid && (acc_op != tdm_pkg::TDM_OP_READ) && !tbl_busy;

  // Table address from both pointers, or last page
  assign prog_addr = tbl_last_page_q ? {tdm_pkg::LAST_PAGE, tbl_low}
                                     : {tbl_hi_ptr[2:0], tbl_low};

  // Two-cycle table sequencer: the start cycle, then one busy cycle
  // A start seen while busy is dropped, so one read never loads the latch twice
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tbl_cnt <= 2'h0;
      tbl_dest_q <= 8'h00;
      tbl_last_page_q <= 1'b0;
    end else if (tbl_start && tbl_cnt == 2'h0) begin
      tbl_cnt <= 2'(tdm_pkg::TBL_CYCLES - 1);
      tbl_dest_q <= tbl_dest;
      tbl_last_page_q <= tbl_last_page;
    end else if (tbl_cnt != 2'h0) begin
      tbl_cnt <= tbl_cnt - 2'h1;
    end
  end
  assign tbl_busy = (tbl_cnt != 2'h0);
  assign tbl_done = (tbl_cnt == 2'h1);

  // Special registers; latch only loaded by a table read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tbl_low <= 8'h00;
      tbl_hi_ptr <= 8'h00;
      mp0 <= 8'h00;
      mp1 <= 8'h00;
      bank_select_bit <= 1'b0;
      table_high_latch <= 8'h00;
    end else begin
      if (tbl_done) begin
        table_high_latch <= prog_data[15:8];
      end
      if (wr_en && !eff_addr[7]) begin
        case (eff_addr)
          tdm_pkg::ADDR_MP0: mp0 <= next_byte;
          tdm_pkg::ADDR_MP1: mp1 <= next_byte;
          tdm_pkg::ADDR_BANK_PTR: bank_select_bit <= next_byte[0];
          tdm_pkg::ADDR_TBL_LOW: tbl_low <= next_byte;
          tdm_pkg::ADDR_TBL_HI_PTR: tbl_hi_ptr <= next_byte;
          default: ; // Latch is read-only, unused slots ignore writes
        endcase
      end
    end
  end

  // Storage arrays; table low byte lands in the destination register when it is 80H-FFH of bank 0
  always_ff @(posedge ref_clk) begin
    if (tbl_done && tbl_dest_q[7]) begin
      gp_mem[tbl_dest_q[6:0]] <= prog_data[7:0];
    end else if (wr_en && eff_addr[7]) begin
      if (eff_bank1) begin
        pwm_mem[eff_addr[6:0]] <= next_byte;
      end else begin
        gp_mem[eff_addr[6:0]] <= next_byte;
      end
    end
  end

  // Checks
  assign prog_hi = prog_data[15:8];
  assign prog_lo = prog_data[7:0];
  assign dest_idx = tbl_dest_q[6:0];
  assign eff_idx = eff_addr[6:0];
  assign next_bit0 = next_byte[0];
  property p_two_cycles;
    @(posedge ref_clk) disable iff (rst) (tbl_start && !tbl_busy) |=> tbl_done;
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("table op not two cycles");
  property p_latch_load;
    @(posedge ref_clk) disable iff (rst) tbl_done |=> table_high_latch == $past(prog_hi);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("high latch not loaded");
  property p_latch_ro;
    @(posedge ref_clk) disable iff (rst) !tbl_done |=> $stable(table_high_latch);
  endproperty
  a_latch_ro: assert property (p_latch_ro) else $error("high latch changed");
  property p_last_page;
    @(posedge ref_clk) disable iff (rst) (tbl_busy && tbl_last_page_q) |-> prog_addr[10:8] == 3'h7;
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page wrong");
  property p_full_addr;
    @(posedge ref_clk) disable iff (rst)
      (tbl_busy && !tbl_last_page_q) |-> prog_addr == {tbl_hi_ptr[2:0], tbl_low};
  endproperty
  a_full_addr: assert property (p_full_addr) else $error("table address wrong");
  property p_unused_zero;
    @(posedge ref_clk) disable iff (rst)
      (acc_valid && !eff_addr[7] && eff_addr > tdm_pkg::ADDR_TBL_HI_PTR) |=> acc_rdata == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused not zero");
  property p_bp_upper;
    @(posedge ref_clk) disable iff (rst)
      (acc_valid && eff_addr == tdm_pkg::ADDR_BANK_PTR) |=> acc_rdata[7:1] == 7'h00;
  endproperty
  a_bp_upper: assert property (p_bp_upper) else $error("bank ptr upper bits");
  property p_direct_bank0;
    @(posedge ref_clk) disable iff (rst)
      (acc_addr != tdm_pkg::ADDR_IND1) |-> !eff_bank1;
  endproperty
  a_direct_bank0: assert property (p_direct_bank0) else $error("direct left bank 0");
  // Write-back checks for table reads, the buffer and the bank select, and the one-cycle busy check
  property p_dest_load;
    @(posedge ref_clk) disable iff (rst)
      (tbl_done && tbl_dest_q[7]) |=> gp_mem[$past(dest_idx)] == $past(prog_lo);
  endproperty
  a_dest_load: assert property (p_dest_load) else $error("table low byte not stored");
  property p_busy_one;
    @(posedge ref_clk) disable iff (rst) tbl_busy |=> !tbl_busy;
  endproperty
  a_busy_one: assert property (p_busy_one) else $error("table op overran");
  property p_pwm_write;
    @(posedge ref_clk) disable iff (rst)
      (wr_en && eff_addr[7] && eff_bank1) |=> pwm_mem[$past(eff_idx)] == $past(next_byte);
  endproperty
  a_pwm_write: assert property (p_pwm_write) else $error("buffer write lost");
  property p_bank_write;
    @(posedge ref_clk) disable iff (rst)
      (wr_en && eff_addr == tdm_pkg::ADDR_BANK_PTR) |=> bank_select_bit == $past(next_bit0);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank select not written");
  // Scenarios worth seeing at least once
  c_tbl: cover property (@(posedge ref_clk) tbl_done);
  c_pwm_wr: cover property (@(posedge ref_clk) wr_en && eff_bank1 && eff_addr[7]);
  c_bset: cover property (@(posedge ref_clk) wr_en && acc_op == tdm_pkg::TDM_OP_BSET);
  c_last_page: cover property (@(posedge ref_clk) tbl_done && tbl_last_page_q);
  c_start_refused: cover property (@(posedge ref_clk) tbl_start && tbl_busy);
endmodule // tdm_core
`default_nettype wire

// File: sim/tdm_prog_mem.sv
// Program memory model answering the table read address
`timescale 1ns/100ps
`default_nettype none
module tdm_prog_mem (
  // Address from the block
  input wire logic [10:0] prog_addr,
  // Word back to the block
  output logic [15:0] prog_data
);
  // Word derived from every address bit, so a wrong page or offset shows up
  assign prog_data = {prog_addr[10:8], prog_addr[4:0] ^ 5'h15, prog_addr[7:0] ^ 8'hC3};
endmodule // tdm_prog_mem
`default_nettype wire

// File: sim/tdm_core_tb_top.sv
// Self-checking testbench for the table read and data memory map block
`timescale 1ns/100ps
`default_nettype none
module tdm_core_tb_top;
  logic ref_clk, rst, acc_valid, acc_indirect, tbl_start, tbl_last_page;
  logic tbl_busy, tbl_done, bank_select_bit;
  tdm_pkg::tdm_op_t acc_op;
  logic [2:0] acc_bit;
  logic [7:0] acc_addr, acc_wdata, acc_rdata, tbl_dest, table_high_latch, rd;
  logic [10:0] prog_addr;
  logic [15:0] prog_data, word;
  int fails = 0;
  int checks = 0;
  tdm_core DUT (.ref_clk(ref_clk), .rst(rst), .acc_valid(acc_valid), .acc_op(acc_op),
    .acc_addr(acc_addr), .acc_indirect(acc_indirect), .acc_bit(acc_bit),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .tbl_start(tbl_start),
    .tbl_last_page(tbl_last_page), .tbl_dest(tbl_dest), .tbl_busy(tbl_busy),
    .tbl_done(tbl_done), .prog_addr(prog_addr), .prog_data(prog_data),
    .table_high_latch(table_high_latch), .bank_select_bit(bank_select_bit));
  tdm_prog_mem mem (.prog_addr(prog_addr), .prog_data(prog_data));
  // Clock at 10 MHz
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One access; read data is registered at the access edge and taken after it
  task automatic acc(input tdm_pkg::tdm_op_t op, input logic [7:0] a, input logic [7:0] w,
    input logic [2:0] b);
    @(negedge ref_clk);
    acc_valid = 1'b1;
    acc_op = op;
    acc_addr = a;
    acc_wdata = w;
    acc_bit = b;
    @(negedge ref_clk);
    acc_valid = 1'b0;
    rd = acc_rdata;
  endtask
  // Table read with expected address a; the word is worked out from a
  task automatic tbl(input logic last, input logic [7:0] dest, input logic [10:0] a);
    @(negedge ref_clk);
    tbl_start = 1'b1;
    tbl_last_page = last;
    tbl_dest = dest;
    @(negedge ref_clk);
    tbl_start = 1'b0;
    chk(prog_addr, a);
    chk({tbl_busy, tbl_done}, 2'b11);
    @(negedge ref_clk);
    chk({tbl_busy, tbl_done}, 2'b00);
    word = {a[10:8], a[4:0] ^ 5'h15, a[7:0] ^ 8'hC3};
    chk(table_high_latch, word[15:8]);
    acc(tdm_pkg::TDM_OP_READ, dest, 8'h00, 3'h0);
    chk(rd, word[7:0]);
  endtask
  task automatic t_table;
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_TBL_LOW, 8'h36, 3'h0);
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_TBL_HI_PTR, 8'hFD, 3'h0);
    tbl(1'b0, 8'h80, 11'h536);
    tbl(1'b1, 8'h81, 11'h736);
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_TBL_HIGH_LATCH, 8'h00, 3'h0);
    chk(table_high_latch, 8'hE3);
  endtask
  task automatic t_map;
    acc(tdm_pkg::TDM_OP_WRITE, 8'h90, 8'hA5, 3'h0);
    acc(tdm_pkg::TDM_OP_READ, 8'h90, 8'h00, 3'h0);
    chk(rd, 8'hA5);
    acc(tdm_pkg::TDM_OP_BSET, 8'h90, 8'h00, 3'h1);
    acc(tdm_pkg::TDM_OP_BCLR, 8'h90, 8'h00, 3'h0);
    acc(tdm_pkg::TDM_OP_READ, 8'h90, 8'h00, 3'h0);
    chk(rd, 8'hA6);
    acc(tdm_pkg::TDM_OP_WRITE, 8'h13, 8'hFF, 3'h0);
    acc(tdm_pkg::TDM_OP_READ, 8'h13, 8'h00, 3'h0);
    chk(rd, 8'h00);
  endtask
  // Bank pointer is set before any bank 1 access
  task automatic t_bank;
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_BANK_PTR, 8'hFF, 3'h0);
    acc(tdm_pkg::TDM_OP_READ, tdm_pkg::ADDR_BANK_PTR, 8'h00, 3'h0);
    chk({rd, 7'h00, bank_select_bit}, 16'h0101);
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_MP1, 8'hC5, 3'h0);
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_IND1, 8'h3C, 3'h0);
    acc(tdm_pkg::TDM_OP_WRITE, 8'hC5, 8'h77, 3'h0);
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_MP0, 8'hC5, 3'h0);
    acc(tdm_pkg::TDM_OP_READ, tdm_pkg::ADDR_IND0, 8'h00, 3'h0);
    chk(rd, 8'h77);
    acc(tdm_pkg::TDM_OP_READ, tdm_pkg::ADDR_IND1, 8'h00, 3'h0);
    chk(rd, 8'h3C);
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_BANK_PTR, 8'h00, 3'h0);
    acc(tdm_pkg::TDM_OP_READ, tdm_pkg::ADDR_IND1, 8'h00, 3'h0);
    chk(rd, 8'h77);
  endtask
  // Start held into the busy cycle and a write there are both refused
  task automatic t_busy;
    @(negedge ref_clk);
    tbl_start = 1'b1;
    tbl_last_page = 1'b1;
    tbl_dest = 8'h82;
    @(negedge ref_clk);
    chk({tbl_busy, tbl_done}, 2'b11);
    acc_valid = 1'b1;
    acc_op = tdm_pkg::TDM_OP_WRITE;
    acc_addr = tdm_pkg::ADDR_TBL_LOW;
    acc_wdata = 8'h99;
    @(negedge ref_clk);
    tbl_start = 1'b0;
    acc_valid = 1'b0;
    chk({tbl_busy, tbl_done}, 2'b00);
    acc(tdm_pkg::TDM_OP_READ, tdm_pkg::ADDR_TBL_LOW, 8'h00, 3'h0);
    chk(rd, 8'h36);
    acc(tdm_pkg::TDM_OP_READ, 8'h82, 8'h00, 3'h0);
    chk(rd, 8'hF5);
  endtask
  // Reset in mid-run clears the latch, the bank select and the read data
  task automatic t_reset;
    acc(tdm_pkg::TDM_OP_WRITE, tdm_pkg::ADDR_BANK_PTR, 8'h01, 3'h0);
    acc(tdm_pkg::TDM_OP_READ, tdm_pkg::ADDR_BANK_PTR, 8'h00, 3'h0);
    chk(rd, 8'h01);
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    chk({table_high_latch, 7'h00, bank_select_bit}, 16'h0000);
    chk(acc_rdata, 8'h00);
    acc(tdm_pkg::TDM_OP_READ, tdm_pkg::ADDR_BANK_PTR, 8'h00, 3'h0);
    chk(rd, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reset held 12 cycles, then the scenarios in turn
  initial begin
    {rst, acc_valid, acc_indirect, tbl_start, tbl_last_page} = 5'h10;
    {acc_addr, acc_wdata, tbl_dest, acc_bit} = 27'h0;
    acc_op = tdm_pkg::TDM_OP_READ;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk({table_high_latch, 7'h00, bank_select_bit}, 16'h0000);
    t_table;
    t_busy;
    t_map;
    t_bank;
    t_reset;
    report_and_stop;
  end
endmodule // tdm_core_tb_top
`default_nettype wire
